//--- cfm_map.svh
`ifndef CFM_MAP_SVH
`define CFM_MAP_SVH

// ----------------------------------------------------------------------------
// Register offsets.
// ----------------------------------------------------------------------------
`define CFM_ADDR_SRC_EN 3'h0
`define CFM_ADDR_TIMEOUTS 3'h1
`define CFM_ADDR_MUTE_CFG 3'h2
`define CFM_ADDR_STICKY 3'h3
`define CFM_ADDR_MASK 3'h4
`define CFM_ADDR_LIVE 3'h5

// ----------------------------------------------------------------------------
// Field positions, reset values and mute depth.
// ----------------------------------------------------------------------------
`define CFM_M1_SRC_BIT 4
`define CFM_M2_SRC_HI 3
`define CFM_M2_SRC_LO 2
`define CFM_M1_EN_BIT 1
`define CFM_M2_EN_BIT 0
`define CFM_M1_TO_HI 5
`define CFM_M1_TO_LO 3
`define CFM_M2_TO_HI 2
`define CFM_M2_TO_LO 0
`define CFM_RAMP_HI 7
`define CFM_RAMP_LO 6
`define CFM_SRC_EN_RST 8'h03
`define CFM_TIMEOUTS_RST 8'h3F
`define CFM_MUTE_CFG_RST 8'h00
`define CFM_MASK_RST 8'h00
`define CFM_MUTE_DB 8'h60

// ----------------------------------------------------------------------------
// Timing.
// ----------------------------------------------------------------------------
`define CFM_CLK_MHZ 250
`define CFM_TO0_US 11000
`define CFM_TO1_US 22000
`define CFM_TO2_US 44000
`define CFM_TO3_US 87000
`define CFM_TO4_US 174000
`define CFM_TO5_US 350000
`define CFM_TO6_US 700000
`define CFM_TO7_US 1200000
`define CFM_RAMP0_US 15
`define CFM_RAMP1_US 30
`define CFM_RAMP2_US 60
`define CFM_RAMP3_US 120
`endif

//--- cfm_pkg.sv
package cfm_pkg;
   typedef logic [7:0] cfm_byte_t;
   typedef logic [2:0] cfm_addr_t;
   typedef enum logic [3:0] {
      CFM_IDLE = 4'h1,
      CFM_RAMP_DN = 4'h2,
      CFM_MUTED = 4'h4,
      CFM_RAMP_UP = 4'h8
   } cfm_mute_state_t;
endpackage

//--- cfm_mon_if.sv
`timescale 1ns/1ps
interface cfm_mon_if;
   logic en;
   logic clk_level;
   logic [31:0] limit;
   logic fault;
   logic fault_rise;
   modport mon (input en, input clk_level, input limit, output fault, output fault_rise);
   modport ctl (output en, output clk_level, output limit, input fault, input fault_rise);
endinterface

//--- cfm_monitor.sv
`timescale 1ns/1ps
`include "cfm_map.svh"
module cfm_monitor (
   input wire logic clk_i,
   input wire logic rst_n_i,
   cfm_mon_if.mon mon
);
   import cfm_pkg::*;

   logic lvl_q;
   logic [31:0] cnt_q;
   logic fault_q;
   logic rise_q;
   logic edge_seen;

   assign edge_seen = mon.clk_level ^ lvl_q;
   assign mon.fault = fault_q;
   assign mon.fault_rise = rise_q;

   // ------------------------------------------------------------------------
   // Absence counter on the reference clock.
   // ------------------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         lvl_q <= 1'b0;
      end else begin
         lvl_q <= mon.clk_level;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_q <= 32'h0;
      end else if (!mon.en || edge_seen) begin
         cnt_q <= 32'h0;
      end else if (cnt_q != mon.limit) begin
         cnt_q <= cnt_q + 32'h1;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         fault_q <= 1'b0;
         rise_q <= 1'b0;
      end else begin
         rise_q <= 1'b0;
         if (!mon.en || edge_seen) begin
            fault_q <= 1'b0;
         end else if (cnt_q == mon.limit) begin
            fault_q <= 1'b1;
            rise_q <= !fault_q;
         end
      end
   end

   property p_disabled_quiet;
      @(posedge clk_i) disable iff (!rst_n_i) !mon.en |=> !fault_q;
   endproperty
   a_disabled_quiet: assert property (p_disabled_quiet) else $error("Disabled detector shows fault.");

   property p_fault_at_limit;
      @(posedge clk_i) disable iff (!rst_n_i)
         (mon.en && !edge_seen && cnt_q == mon.limit && !fault_q) |=> (fault_q && rise_q);
   endproperty
   a_fault_at_limit: assert property (p_fault_at_limit) else $error("Fault not raised at timeout.");

   property p_edge_clears;
      @(posedge clk_i) disable iff (!rst_n_i) (mon.en && edge_seen) |=> (!fault_q && cnt_q == 32'h0);
   endproperty
   a_edge_clears: assert property (p_edge_clears) else $error("Clock edge did not clear detector.");
endmodule

//--- cfm_top.sv
`timescale 1ns/1ps
`include "cfm_map.svh"
module cfm_top #(
   parameter int unsigned TIMEOUT_CYC [8] = '{
      `CFM_TO0_US * `CFM_CLK_MHZ, `CFM_TO1_US * `CFM_CLK_MHZ,
      `CFM_TO2_US * `CFM_CLK_MHZ, `CFM_TO3_US * `CFM_CLK_MHZ,
      `CFM_TO4_US * `CFM_CLK_MHZ, `CFM_TO5_US * `CFM_CLK_MHZ,
      `CFM_TO6_US * `CFM_CLK_MHZ, `CFM_TO7_US * `CFM_CLK_MHZ},
   parameter int unsigned RAMP_CYC [4] = '{
      `CFM_RAMP0_US * `CFM_CLK_MHZ, `CFM_RAMP1_US * `CFM_CLK_MHZ,
      `CFM_RAMP2_US * `CFM_CLK_MHZ, `CFM_RAMP3_US * `CFM_CLK_MHZ}
) (
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   input wire logic master_clk_i,
   input wire logic serial_port_clock_i,
   input wire logic pulse_density_clock_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire cfm_pkg::cfm_addr_t reg_addr_i,
   input wire cfm_pkg::cfm_byte_t reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   output logic divider_half_clock_o,
   output logic playback_modulator_clock_o,
   output logic sense_modulator_clock_o,
   output logic [7:0] gain_atten_db_o,
   output logic muted_o,
   output logic irq_o
);
   import cfm_pkg::*;

   // ------------------------------------------------------------------------
   // Helper functions.
   // ------------------------------------------------------------------------
   function automatic logic [31:0] timeout_cycles(input logic [2:0] code);
      timeout_cycles = 32'(TIMEOUT_CYC[code]);
   endfunction

   function automatic logic [31:0] ramp_cycles(input logic [1:0] code);
      ramp_cycles = 32'(RAMP_CYC[code]);
   endfunction

   // ------------------------------------------------------------------------
   // Reset release.
   // ------------------------------------------------------------------------
   logic rst_meta_q;
   logic rst_n;

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rst_meta_q <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n <= rst_meta_q;
      end
   end

   // ------------------------------------------------------------------------
   // Clock tree dividers.
   // ------------------------------------------------------------------------
   logic master_q;
   logic master_rise;
   logic [3:0] div_cnt_q;
   logic sense_mod_q;

   assign master_rise = master_clk_i & ~master_q;
   assign divider_half_clock_o = div_cnt_q[0];
   assign playback_modulator_clock_o = div_cnt_q[3];
   assign sense_modulator_clock_o = sense_mod_q;

   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         master_q <= 1'b0;
      end else begin
         master_q <= master_clk_i;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         div_cnt_q <= 4'h0;
         sense_mod_q <= 1'b0;
      end else if (master_rise) begin
         div_cnt_q <= div_cnt_q + 4'h1;
         if (div_cnt_q[2:0] == 3'h7) begin
            sense_mod_q <= ~sense_mod_q;
         end
      end
   end

   property p_half_toggles;
      @(posedge ref_clk_i) disable iff (!rst_n)
         master_rise |=> (divider_half_clock_o != $past(divider_half_clock_o));
   endproperty
   a_half_toggles: assert property (p_half_toggles) else $error("Half clock missed a toggle.");

   property p_mod_sixteenth;
      @(posedge ref_clk_i) disable iff (!rst_n)
         (master_rise && div_cnt_q[2:0] != 3'h7) |=> $stable(playback_modulator_clock_o) && $stable(sense_mod_q);
   endproperty
   a_mod_sixteenth: assert property (p_mod_sixteenth) else $error("Modulator clock toggled early.");

   // ------------------------------------------------------------------------
   // Configuration registers.
   // ------------------------------------------------------------------------
   cfm_byte_t src_en_q;
   cfm_byte_t timeouts_q;
   cfm_byte_t mute_cfg_q;
   logic [1:0] mask_q;
   logic [1:0] sticky_q;

   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         src_en_q <= `CFM_SRC_EN_RST;
         timeouts_q <= `CFM_TIMEOUTS_RST;
         mute_cfg_q <= `CFM_MUTE_CFG_RST;
         mask_q <= 2'(`CFM_MASK_RST);
      end else if (reg_wr_i) begin
         case (reg_addr_i)
            `CFM_ADDR_SRC_EN: begin
               src_en_q <= reg_wdata_i & 8'h1F;
            end
            `CFM_ADDR_TIMEOUTS: begin
               timeouts_q <= reg_wdata_i & 8'h3F;
            end
            `CFM_ADDR_MUTE_CFG: begin
               mute_cfg_q <= reg_wdata_i & 8'hC0;
            end
            `CFM_ADDR_MASK: begin
               mask_q <= reg_wdata_i[1:0];
            end
            default: begin
            end
         endcase
      end
   end

   // ------------------------------------------------------------------------
   // Detectors.
   // ------------------------------------------------------------------------
   cfm_mon_if mon1 ();
   cfm_mon_if mon2 ();

   logic [1:0] m2_src;
   logic fault_any;

   assign m2_src = src_en_q[`CFM_M2_SRC_HI:`CFM_M2_SRC_LO];
   assign mon1.en = src_en_q[`CFM_M1_EN_BIT];
   assign mon2.en = src_en_q[`CFM_M2_EN_BIT] && (m2_src != 2'h3);
   assign mon1.clk_level = src_en_q[`CFM_M1_SRC_BIT] ? pulse_density_clock_i : serial_port_clock_i;
   assign mon1.limit = timeout_cycles(timeouts_q[`CFM_M1_TO_HI:`CFM_M1_TO_LO]);
   assign mon2.limit = timeout_cycles(timeouts_q[`CFM_M2_TO_HI:`CFM_M2_TO_LO]);
   assign fault_any = mon1.fault | mon2.fault;

   always_comb begin
      case (m2_src)
         2'h0: mon2.clk_level = div_cnt_q[3];
         2'h1: mon2.clk_level = sense_mod_q;
         2'h2: mon2.clk_level = master_clk_i;
         default: mon2.clk_level = 1'b0;
      endcase
   end

   cfm_monitor u_mon1 (
      .clk_i(ref_clk_i),
      .rst_n_i(rst_n),
      .mon(mon1.mon)
   );

   cfm_monitor u_mon2 (
      .clk_i(ref_clk_i),
      .rst_n_i(rst_n),
      .mon(mon2.mon)
   );

   // ------------------------------------------------------------------------
   // Sticky flags, readback and interrupt.
   // ------------------------------------------------------------------------
   logic sticky_rd;
   logic [1:0] fault_set;

   assign sticky_rd = reg_rd_i && (reg_addr_i == `CFM_ADDR_STICKY);
   assign fault_set = {mon2.fault_rise, mon1.fault_rise};

   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         sticky_q <= 2'h0;
      end else if (sticky_rd) begin
         sticky_q <= fault_set;
      end else begin
         sticky_q <= sticky_q | fault_set;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(sticky_q & mask_q);
      end
   end

   cfm_mute_state_t state_q;

   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_rd_i) begin
         case (reg_addr_i)
            `CFM_ADDR_SRC_EN: reg_rdata_o <= src_en_q;
            `CFM_ADDR_TIMEOUTS: reg_rdata_o <= timeouts_q;
            `CFM_ADDR_MUTE_CFG: reg_rdata_o <= mute_cfg_q;
            `CFM_ADDR_STICKY: reg_rdata_o <= {6'h00, sticky_q};
            `CFM_ADDR_MASK: reg_rdata_o <= {6'h00, mask_q};
            `CFM_ADDR_LIVE: reg_rdata_o <= {4'h0, state_q == CFM_MUTED, fault_any, mon2.fault, mon1.fault};
            default: reg_rdata_o <= 8'h00;
         endcase
      end
   end

   property p_irq_follows;
      @(posedge ref_clk_i) disable iff (!rst_n) |(sticky_q & mask_q) |=> irq_o;
   endproperty
   a_irq_follows: assert property (p_irq_follows) else $error("Unmasked flag gave no interrupt.");

   property p_read_clears;
      @(posedge ref_clk_i) disable iff (!rst_n)
         (sticky_rd && fault_set == 2'h0) |=> (sticky_q == 2'h0) ##1 !irq_o;
   endproperty
   a_read_clears: assert property (p_read_clears) else $error("Read did not clear sticky flags.");

   // ------------------------------------------------------------------------
   // Soft-mute ramp.
   // ------------------------------------------------------------------------
   logic [31:0] step_cnt_q;
   logic step_due;
   logic [7:0] atten_q;

   assign step_due = (step_cnt_q >= ramp_cycles(mute_cfg_q[`CFM_RAMP_HI:`CFM_RAMP_LO]) - 32'h1);
   assign gain_atten_db_o = atten_q;

   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         step_cnt_q <= 32'h0;
      end else if ((state_q == CFM_RAMP_DN || state_q == CFM_RAMP_UP) && !step_due) begin
         step_cnt_q <= step_cnt_q + 32'h1;
      end else begin
         step_cnt_q <= 32'h0;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= CFM_IDLE;
         atten_q <= 8'h00;
      end else begin
         case (state_q)
            CFM_IDLE: begin
               if (fault_any) begin
                  state_q <= CFM_RAMP_DN;
               end
            end
            CFM_RAMP_DN: begin
               if (!fault_any) begin
                  state_q <= CFM_RAMP_UP;
               end else if (step_due) begin
                  atten_q <= atten_q + 8'h01;
                  if (atten_q == `CFM_MUTE_DB - 8'h01) begin
                     state_q <= CFM_MUTED;
                  end
               end
            end
            CFM_MUTED: begin
               if (!fault_any) begin
                  state_q <= CFM_RAMP_UP;
               end
            end
            CFM_RAMP_UP: begin
               if (fault_any) begin
                  state_q <= CFM_RAMP_DN;
               end else if (atten_q == 8'h00) begin
                  state_q <= CFM_IDLE;
               end else if (step_due) begin
                  atten_q <= atten_q - 8'h01;
               end
            end
            default: begin
               state_q <= CFM_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         muted_o <= 1'b0;
      end else begin
         muted_o <= (state_q != CFM_IDLE);
      end
   end

   property p_fault_mutes;
      @(posedge ref_clk_i) disable iff (!rst_n)
         (state_q == CFM_IDLE && fault_any) |=> (state_q == CFM_RAMP_DN) ##1 muted_o;
   endproperty
   a_fault_mutes: assert property (p_fault_mutes) else $error("Fault did not start soft-mute.");

   property p_step_down;
      @(posedge ref_clk_i) disable iff (!rst_n)
         (state_q == CFM_RAMP_DN && fault_any && step_due) |=> (atten_q == $past(atten_q) + 8'h01);
   endproperty
   a_step_down: assert property (p_step_down) else $error("Ramp-down step not 1 dB.");

   property p_hold_between;
      @(posedge ref_clk_i) disable iff (!rst_n)
         (state_q == CFM_RAMP_DN && !step_due) |=> $stable(atten_q);
   endproperty
   a_hold_between: assert property (p_hold_between) else $error("Gain moved before interval.");

   property p_unmute;
      @(posedge ref_clk_i) disable iff (!rst_n)
         (state_q == CFM_MUTED && !fault_any) |=> (state_q == CFM_RAMP_UP);
   endproperty
   a_unmute: assert property (p_unmute) else $error("Clock return did not start un-mute.");
endmodule

//--- cfm_clk_src.sv
`timescale 1ns/1ps
module cfm_clk_src #(
   parameter int M_HALF_NS = 8,
   parameter int S_HALF_NS = 16,
   parameter int P_HALF_NS = 12
) (
   input wire logic run_master_i,
   input wire logic run_serial_i,
   input wire logic run_pdm_i,
   output logic master_clk_o,
   output logic serial_port_clock_o,
   output logic pulse_density_clock_o
);
   // ------------------------------------------------------------
   // Free-running clock sources; a stopped clock rests low.
   // ------------------------------------------------------------
   initial begin
      master_clk_o = 1'b0;
      forever #(M_HALF_NS) master_clk_o = run_master_i & ~master_clk_o;
   end
   initial begin
      serial_port_clock_o = 1'b0;
      forever #(S_HALF_NS) serial_port_clock_o = run_serial_i & ~serial_port_clock_o;
   end
   initial begin
      pulse_density_clock_o = 1'b0;
      forever #(P_HALF_NS) pulse_density_clock_o = run_pdm_i & ~pulse_density_clock_o;
   end
endmodule

//--- testbench.sv
`timescale 1ns/1ps
`include "cfm_map.svh"
module testbench;
   import cfm_pkg::*;
   localparam int unsigned TO_CYC [8] = '{20, 30, 40, 50, 60, 70, 80, 90};
   localparam int unsigned RP_CYC [4] = '{2, 3, 4, 5};
   localparam int MP = 4;
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   cfm_addr_t reg_addr = 3'h0;
   cfm_byte_t reg_wdata = 8'h00;
   logic run_master = 1'b1;
   logic run_serial = 1'b1;
   logic run_pdm = 1'b1;
   logic master_clk, serial_clk, pulse_density_clock, div_clk, play_clk, sense_clk, muted, irq;
   logic [7:0] reg_rdata, gain;
   int miscompares = 0;
   int num_checks = 0;

   always #2 ref_clk = ~ref_clk;

   cfm_clk_src cfm_clk_src_i (.run_master_i(run_master), .run_serial_i(run_serial), .run_pdm_i(run_pdm),
      .master_clk_o(master_clk), .serial_port_clock_o(serial_clk), .pulse_density_clock_o(pulse_density_clock));

   cfm_top #(.TIMEOUT_CYC(TO_CYC), .RAMP_CYC(RP_CYC)) cfm_top_i (.ref_clk_i(ref_clk), .rst_b_i(rst_b),
      .master_clk_i(master_clk), .serial_port_clock_i(serial_clk), .pulse_density_clock_i(pulse_density_clock),
      .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
      .reg_rdata_o(reg_rdata), .divider_half_clock_o(div_clk), .playback_modulator_clock_o(play_clk),
      .sense_modulator_clock_o(sense_clk), .gain_atten_db_o(gain), .muted_o(muted), .irq_o(irq));

   // ------------------------------------------------------------
   // Shared tasks.
   // ------------------------------------------------------------
   task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t ns: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic check_rng(input int n, input int lo, input int hi, input string what);
      num_checks++;
      if (n < lo || n > hi) begin
         miscompares++;
         $display("Error at %0t ns: %s took %0d cycles", $time, what, n);
      end
   endtask

   task automatic reg_write(input cfm_addr_t a, input cfm_byte_t d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic reg_read(input cfm_addr_t a, output cfm_byte_t d);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   task automatic rd_chk(input cfm_addr_t a, input cfm_byte_t exp, input string what);
      cfm_byte_t d;
      reg_read(a, d);
      check(d, exp, what);
   endtask

   task automatic wait_for(input bit on_gain, input logic [7:0] v, input int lim, output int n);
      n = 0;
      while ((on_gain ? gain : {7'h00, muted}) !== v && n < lim) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      check(on_gain ? gain : {7'h00, muted}, v, "wait target");
   endtask

   task automatic step(output int n, output logic [7:0] a, output logic [7:0] b);
      a = gain;
      n = 0;
      while (gain === a && n < 50) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      a = gain;
      n = 0;
      while (gain === a && n < 50) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      b = gain;
   endtask

   task automatic tree_period(input int w, output int n);
      logic prev;
      int seen;
      seen = 0;
      n = 0;
      prev = 1'b1;
      for (int k = 0; k < 400 && seen < 2; k++) begin
         @(posedge ref_clk);
         #1;
         if (seen == 1) begin
            n++;
         end
         if (prev === 1'b0 && (w == 0 ? div_clk : w == 1 ? play_clk : sense_clk) === 1'b1) begin
            seen++;
         end
         prev = (w == 0) ? div_clk : (w == 1) ? play_clk : sense_clk;
      end
   endtask

   // ------------------------------------------------------------
   // Scenarios.
   // ------------------------------------------------------------
   task automatic test_regs;
      rd_chk(`CFM_ADDR_SRC_EN, 8'h03, "src_en reset");
      rd_chk(`CFM_ADDR_TIMEOUTS, 8'h3F, "timeouts reset");
      rd_chk(`CFM_ADDR_MUTE_CFG, 8'h00, "mute_cfg reset");
      reg_write(`CFM_ADDR_TIMEOUTS, 8'h2A);
      rd_chk(`CFM_ADDR_TIMEOUTS, 8'h2A, "timeouts rw");
      reg_write(`CFM_ADDR_MUTE_CFG, 8'hC0);
      rd_chk(`CFM_ADDR_MUTE_CFG, 8'hC0, "mute_cfg rw");
      rd_chk(3'h6, 8'h00, "unmapped read");
      $display("Test regs done");
   endtask

   task automatic test_tree;
      int n;
      for (int w = 0; w < 3; w++) begin
         tree_period(w, n);
         check_rng(n, (w == 0) ? 2 * MP : 16 * MP, (w == 0) ? 2 * MP : 16 * MP, "tree period");
      end
      $display("Test tree done");
   endtask

   task automatic test_timeouts;
      int n;
      for (int c = 0; c < 8; c++) begin
         reg_write(`CFM_ADDR_TIMEOUTS, {2'b00, c[2:0], 3'b111});
         @(posedge ref_clk);
         run_serial <= 1'b0;
         wait_for(0, 8'h01, 200, n);
         check_rng(n, TO_CYC[c], TO_CYC[c] + 10, "det1 timeout");
         rd_chk(`CFM_ADDR_STICKY, 8'h01, "sticky det1");
         @(posedge ref_clk);
         run_serial <= 1'b1;
         wait_for(0, 8'h00, 1200, n);
      end
      $display("Test timeouts done");
   endtask

   task automatic test_ramp;
      int n;
      logic [7:0] a, b;
      reg_write(`CFM_ADDR_TIMEOUTS, 8'h07);
      for (int r = 0; r < 4; r++) begin
         reg_write(`CFM_ADDR_MUTE_CFG, {r[1:0], 6'h00});
         @(posedge ref_clk);
         run_serial <= 1'b0;
         wait_for(0, 8'h01, 200, n);
         step(n, a, b);
         check_rng(n, RP_CYC[r], RP_CYC[r], "down step time");
         check(b, a + 8'h01, "down step");
         wait_for(1, `CFM_MUTE_DB, 700, n);
         rd_chk(`CFM_ADDR_LIVE, 8'h0D, "live muted");
         @(posedge ref_clk);
         run_serial <= 1'b1;
         step(n, a, b);
         check_rng(n, RP_CYC[r], RP_CYC[r], "up step time");
         check(b, a - 8'h01, "up step");
         wait_for(0, 8'h00, 1200, n);
         check(gain, 8'h00, "full gain");
         reg_read(`CFM_ADDR_STICKY, a);
      end
      $display("Test ramp done");
   endtask

   task automatic test_irq;
      int n;
      reg_write(`CFM_ADDR_MASK, 8'h00);
      @(posedge ref_clk);
      run_serial <= 1'b0;
      wait_for(0, 8'h01, 200, n);
      repeat (4) @(posedge ref_clk);
      #1 check({7'h00, irq}, 8'h00, "irq masked");
      @(posedge ref_clk);
      run_serial <= 1'b1;
      wait_for(0, 8'h00, 1200, n);
      reg_write(`CFM_ADDR_MASK, 8'h01);
      repeat (3) @(posedge ref_clk);
      #1 check({7'h00, irq}, 8'h01, "irq unmasked");
      rd_chk(`CFM_ADDR_STICKY, 8'h01, "sticky held");
      repeat (3) @(posedge ref_clk);
      #1 check({7'h00, irq}, 8'h00, "irq after read");
      rd_chk(`CFM_ADDR_STICKY, 8'h00, "sticky cleared");
      $display("Test irq done");
   endtask

   task automatic test_sources;
      int n;
      reg_write(`CFM_ADDR_SRC_EN, 8'h13);
      rd_chk(`CFM_ADDR_SRC_EN, 8'h13, "src_en rw");
      @(posedge ref_clk);
      run_serial <= 1'b0;
      repeat (150) @(posedge ref_clk);
      #1 check({7'h00, muted}, 8'h00, "serial ignored");
      @(posedge ref_clk);
      run_pdm <= 1'b0;
      wait_for(0, 8'h01, 200, n);
      check_rng(n, TO_CYC[0], TO_CYC[0] + 10, "pdm timeout");
      @(posedge ref_clk);
      run_pdm <= 1'b1;
      run_serial <= 1'b1;
      wait_for(0, 8'h00, 1200, n);
      rd_chk(`CFM_ADDR_STICKY, 8'h01, "sticky pdm");
      reg_write(`CFM_ADDR_SRC_EN, 8'h0B);
      reg_write(`CFM_ADDR_TIMEOUTS, 8'h38);
      @(posedge ref_clk);
      run_master <= 1'b0;
      wait_for(0, 8'h01, 200, n);
      check_rng(n, TO_CYC[0], TO_CYC[0] + 10, "det2 timeout");
      rd_chk(`CFM_ADDR_STICKY, 8'h02, "sticky det2");
      @(posedge ref_clk);
      run_master <= 1'b1;
      wait_for(0, 8'h00, 1200, n);
      reg_write(`CFM_ADDR_TIMEOUTS, 8'h3F);
      reg_write(`CFM_ADDR_SRC_EN, 8'h07);
      @(posedge ref_clk);
      run_master <= 1'b0;
      wait_for(0, 8'h01, 200, n);
      check_rng(n, TO_CYC[7] - 32, TO_CYC[7] + 10, "sense timeout");
      rd_chk(`CFM_ADDR_STICKY, 8'h02, "sticky sense");
      @(posedge ref_clk);
      run_master <= 1'b1;
      wait_for(0, 8'h00, 1200, n);
      reg_write(`CFM_ADDR_SRC_EN, 8'h0F);
      @(posedge ref_clk);
      run_master <= 1'b0;
      repeat (150) @(posedge ref_clk);
      #1 check({7'h00, muted}, 8'h00, "reserved source");
      @(posedge ref_clk);
      run_master <= 1'b1;
      $display("Test sources done");
   endtask

   task automatic test_disable;
      reg_write(`CFM_ADDR_SRC_EN, 8'h00);
      @(posedge ref_clk);
      run_serial <= 1'b0;
      run_master <= 1'b0;
      repeat (200) @(posedge ref_clk);
      #1 check({7'h00, muted}, 8'h00, "disabled no mute");
      rd_chk(`CFM_ADDR_STICKY, 8'h00, "disabled no flag");
      @(posedge ref_clk);
      run_serial <= 1'b1;
      run_master <= 1'b1;
      $display("Test disable done");
   endtask

   task automatic test_done;
      $display("Checks %0d, mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   initial begin
      repeat (10) @(posedge ref_clk);
      rst_b <= 1'b1;
      repeat (5) @(posedge ref_clk);
      test_regs;
      test_tree;
      test_timeouts;
      test_ramp;
      test_irq;
      test_sources;
      test_disable;
      test_done;
   end

   initial begin
      repeat (60000) @(posedge ref_clk);
      miscompares++;
      $display("Error at %0t ns: watchdog expired", $time);
      test_done;
   end
endmodule
